// ==== src/ppc_pkg.sv ====
// Purpose: Constants and types for the panel output and pixel configuration block
// Assumes: 32-bit register port with byte addresses
// Notes:   Field positions are bit indices inside each register
package ppc_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [19:0] OFS_PANEL_CTL = 20'h60018;
  localparam logic [19:0] OFS_OVR_WIN   = 20'h6001C;
  localparam logic [19:0] OFS_BORDER    = 20'h60020;
  localparam logic [19:0] OFS_PIX_CFG   = 20'h70008;

  // ==========================================================================
  // Writable bit masks and reset values
  localparam logic [31:0] MASK_PANEL_CTL = 32'hB000_4FFF;
  localparam logic [31:0] MASK_OVR_WIN   = 32'h07FF_0FFF;
  localparam logic [31:0] MASK_BORDER    = 32'h01FF_FFFF;
  localparam logic [31:0] MASK_PIX_CFG   = 32'h0C1F_9D03;
  localparam logic [31:0] RST_REG        = 32'h0000_0000;

  // ==========================================================================
  // Panel control fields
  localparam int C_OUT_EN   = 31;
  localparam int C_PASS     = 28;
  localparam int C_VS_DIS   = 11;
  localparam int C_HS_DIS   = 10;
  localparam int C_VS_TRI   = 9;
  localparam int C_HS_TRI   = 8;
  localparam int C_BORDER   = 7;
  localparam int C_ORDER    = 6;
  localparam int C_INVERT   = 5;
  localparam int C_VS_POL   = 4;
  localparam int C_HS_POL   = 3;
  localparam int C_BLK_POL  = 2;
  localparam int C_CLK_SRC  = 1;
  localparam int C_PLL_LOCK = 0;

  // ==========================================================================
  // Pixel configuration fields
  localparam int P_GFX_GAMMA = 27;
  localparam int P_OVL_GAMMA = 26;
  localparam int P_NO_DELAY  = 20;
  localparam int P_MODE_LO   = 16;
  localparam int P_DAC8      = 15;
  localparam int P_EXT_STAT  = 11;

  // Colour mode codes
  localparam logic [3:0] MODE_VGA    = 4'h0;
  localparam logic [3:0] MODE_8      = 4'h2;
  localparam logic [3:0] MODE_555    = 4'h4;
  localparam logic [3:0] MODE_565    = 4'h5;
  localparam logic [3:0] MODE_24C    = 4'h6;
  localparam logic [3:0] MODE_24U    = 4'h7;

  // Divider set selected while locked
  localparam logic [1:0] PLL_SET_PANEL = 2'h3;

  // DAC port selects
  localparam logic [1:0] DAC_PORT_MASK  = 2'h0;
  localparam logic [1:0] DAC_PORT_WX    = 2'h1;
  localparam logic [1:0] DAC_PORT_STATE = 2'h2;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic        hsync;
    logic        vsync;
    logic        blank;
    logic        border;
    logic        pseudo_border;
    logic [23:0] rgb;
  } ppc_tg_t;

  typedef struct packed {
    logic [31:0] ctl;
    logic [31:0] ovr;
    logic [31:0] bclr;
    logic [31:0] pix;
    logic [31:0] rdata;
    logic        phase;
    logic [11:0] hold;
    logic [11:0] data;
    logic [1:0]  pclk;
    logic        hs;
    logic        vs;
    logic        blank;
    logic [23:0] fetch;
    logic [7:0]  dac_rdata;
  } ppc_state_t;

endpackage : ppc_pkg

// ==== src/ppc_top.sv ====
// Purpose: Panel/TV output control, border, overlay window and pixel configuration
// Assumes: Runs on the dot clock; inputs synchronous to clk_i
// Notes:   Pin outputs come with separate output enables
//
// Summary of operation
// - Vertical sync disabled: follows VGA vsync in passthrough, else deasserted level.
// - Horizontal sync disabled: follows VGA hsync in passthrough, else deasserted level.
// - Sync enabled: VGA generator in passthrough, panel generator otherwise.
// - Bits 9 and 8 tristate vertical and horizontal sync; output enable also gates.
// - Bit 7 sends border pixels to the panel encoder.
// - Pixel sent in two halves; bit 6 swaps halves, bit 5 inverts data.
// - Bits 4,3,2 set sync and blank polarity; syncs keep VGA polarity in passthrough, blank still uses bit 2.
// - Bit 1 selects external clock pin as dot-clock PLL reference.
// - Hot-plug interrupt held deasserted while the pin serves as clock.
// - Clock pin always input; pull-up on as interrupt, off as clock.
// - Bit 0 locks PLL to panel dividers, ignoring misc output register.
// - Overlay end uses all bits when panel enabled, character resolution otherwise.
// - Overlay start uses all bits when panel enabled, character resolution otherwise.
// - Border colour output when border enabled and during pseudo-border period.
// - Bits 27 and 26 route graphics and overlay through the palette.
// - Bit 20 clear delays CRT display enable and blank against syncs.
// - Colour-mode field selects pixel format; codes 1, 3 and 8 to 15 reserved.
// - Uncompressed 24-bit pixels use the low three bytes of each word.
// - Bit 15 selects 8-bit DAC; 6-bit after reset.
// - Extended status read redirects DAC port reads to holding values and status.
// - Output enable clear tristates panel outputs and holds the timing generator.
// - Bit 28 selects VGA timing and sync polarity passthrough, else panel timing.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module ppc_top (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [19:0]      reg_addr_i,
  input  wire logic [31:0]      reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic      [31:0]      reg_rdata_o,
  input  wire ppc_pkg::ppc_tg_t tg_i,
  input  wire logic             vga_hsync_i,
  input  wire logic             vga_vsync_i,
  input  wire logic             vga_blank_i,
  output logic                  panel_horizontal_sync_pin_o,
  output logic                  panel_horizontal_sync_pin_oe_o,
  output logic                  panel_vertical_sync_pin_o,
  output logic                  panel_vertical_sync_pin_oe_o,
  output logic                  panel_blank_pin_o,
  output logic                  panel_blank_pin_oe_o,
  output logic      [11:0]      panel_data_outputs_o,
  output logic                  panel_data_outputs_oe_o,
  output logic      [1:0]       panel_clock_outputs_o,
  output logic                  panel_clock_outputs_oe_o,
  output logic                  tg_hold_o,
  output logic                  legacy_timing_passthrough_mode_o,
  input  wire logic             external_clock_in_pin_i,
  output logic                  clk_pin_pullup_en_o,
  output logic                  hotplug_int_o,
  output logic                  pll_ref_external_o,
  input  wire logic [1:0]       misc_output_register_clk_sel_i,
  output logic      [1:0]       pll_divider_sel_o,
  output logic      [11:0]      ovl_start_o,
  output logic      [10:0]      ovl_end_o,
  output logic                  gfx_through_palette_o,
  output logic                  ovl_through_palette_o,
  output logic                  crt_ctl_delay_o,
  output logic      [3:0]       color_mode_o,
  output logic                  color_mode_reserved_o,
  input  wire logic [31:0]      fb_word_i,
  output logic      [23:0]      fetch_rgb_o,
  output logic                  dac_8bit_o,
  input  wire logic [1:0]       dac_port_sel_i,
  input  wire logic [7:0]       dac_normal_rdata_i,
  input  wire logic [7:0]       dac_red_hold_i,
  input  wire logic [7:0]       dac_green_hold_i,
  input  wire logic [5:0]       dac_fsm_status_i,
  output logic      [7:0]       dac_rdata_o
);

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] mask,
                                        input logic [31:0] wdata);
    merge = wdata & mask;
  endfunction : merge

  function automatic logic sync_level(input logic dis, input logic pass,
                                      input logic vga, input logic tg,
                                      input logic pol);
    if (pass) begin
      sync_level = vga;
    end else if (dis) begin
      sync_level = ~pol;
    end else begin
      sync_level = tg ? pol : ~pol;
    end
  endfunction : sync_level

  function automatic logic [11:0] char_res(input logic [11:0] v,
                                           input logic en);
    char_res = en ? v : {v[11:3], 3'h0};
  endfunction : char_res

  // ==========================================================================
  // State
  ppc_pkg::ppc_state_t s_q;
  ppc_pkg::ppc_state_t s_d;

  logic        out_en;
  logic        pass;
  logic [23:0] rgb;
  logic [11:0] half_a;
  logic [11:0] half_b;
  logic [3:0]  mode;

  always_comb begin
    s_d    = s_q;
    out_en = s_q.ctl[ppc_pkg::C_OUT_EN];
    pass   = s_q.ctl[ppc_pkg::C_PASS];
    mode   = s_q.pix[ppc_pkg::P_MODE_LO +: 4];

    // Register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        ppc_pkg::OFS_PANEL_CTL: begin
          s_d.ctl = merge(ppc_pkg::MASK_PANEL_CTL, reg_wdata_i);
        end
        ppc_pkg::OFS_OVR_WIN: begin
          s_d.ovr = merge(ppc_pkg::MASK_OVR_WIN, reg_wdata_i);
        end
        ppc_pkg::OFS_BORDER: begin
          s_d.bclr = merge(ppc_pkg::MASK_BORDER, reg_wdata_i);
        end
        ppc_pkg::OFS_PIX_CFG: begin
          s_d.pix = merge(ppc_pkg::MASK_PIX_CFG, reg_wdata_i);
        end
        default: begin
        end
      endcase
    end

    // Register reads, unmapped reads return zero
    s_d.rdata = '0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        ppc_pkg::OFS_PANEL_CTL: s_d.rdata = s_q.ctl;
        ppc_pkg::OFS_OVR_WIN:   s_d.rdata = s_q.ovr;
        ppc_pkg::OFS_BORDER:    s_d.rdata = s_q.bclr;
        ppc_pkg::OFS_PIX_CFG:   s_d.rdata = s_q.pix;
        default:                s_d.rdata = '0;
      endcase
    end

    // Pixel source with border substitution
    rgb = tg_i.rgb;
    if ((tg_i.border && s_q.ctl[ppc_pkg::C_BORDER]) || tg_i.pseudo_border) begin
      rgb = {s_q.bclr[23:16], s_q.bclr[15:8], s_q.bclr[7:0]};
    end else if (tg_i.border) begin
      rgb = '0;
    end

    // Half-pixel ordering and inversion
    half_a = {rgb[23:16], rgb[15:12]};
    half_b = {rgb[11:8], rgb[7:0]};
    if (s_q.ctl[ppc_pkg::C_ORDER]) begin
      half_a = {rgb[11:8], rgb[7:0]};
      half_b = {rgb[23:16], rgb[15:12]};
    end
    if (s_q.ctl[ppc_pkg::C_INVERT]) begin
      half_a = ~half_a;
      half_b = ~half_b;
    end

    if (out_en) begin
      s_d.phase = ~s_q.phase;
      if (!s_q.phase) begin
        s_d.data = half_a;
        s_d.hold = half_b;
      end else begin
        s_d.data = s_q.hold;
      end
    end else begin
      s_d.phase = 1'b0;
      s_d.data  = '0;
      s_d.hold  = '0;
    end
    s_d.pclk = {s_d.phase, ~s_d.phase};

    // Syncs and blank
    s_d.hs = sync_level(s_q.ctl[ppc_pkg::C_HS_DIS], pass, vga_hsync_i,
                        tg_i.hsync, s_q.ctl[ppc_pkg::C_HS_POL]);
    s_d.vs = sync_level(s_q.ctl[ppc_pkg::C_VS_DIS], pass, vga_vsync_i,
                        tg_i.vsync, s_q.ctl[ppc_pkg::C_VS_POL]);
    s_d.blank = (pass ? vga_blank_i : tg_i.blank) ?
                s_q.ctl[ppc_pkg::C_BLK_POL] : ~s_q.ctl[ppc_pkg::C_BLK_POL];

    // Uncompressed 24-bit fetch drops the top byte
    s_d.fetch = (mode == ppc_pkg::MODE_24U) ? fb_word_i[23:0] : '0;

    // DAC port read redirection
    s_d.dac_rdata = dac_normal_rdata_i;
    if (s_q.pix[ppc_pkg::P_EXT_STAT]) begin
      case (dac_port_sel_i)
        ppc_pkg::DAC_PORT_MASK:  s_d.dac_rdata = dac_red_hold_i;
        ppc_pkg::DAC_PORT_WX:    s_d.dac_rdata = dac_green_hold_i;
        ppc_pkg::DAC_PORT_STATE: s_d.dac_rdata = {dac_fsm_status_i, 2'h0};
        default:                 s_d.dac_rdata = dac_normal_rdata_i;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q      <= '0;
      s_q.ctl  <= ppc_pkg::RST_REG;
      s_q.ovr  <= ppc_pkg::RST_REG;
      s_q.bclr <= ppc_pkg::RST_REG;
      s_q.pix  <= ppc_pkg::RST_REG;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata_o = s_q.rdata;

  assign panel_horizontal_sync_pin_o    = s_q.hs;
  assign panel_horizontal_sync_pin_oe_o = s_q.ctl[ppc_pkg::C_OUT_EN] &
                                          ~s_q.ctl[ppc_pkg::C_HS_TRI];
  assign panel_vertical_sync_pin_o      = s_q.vs;
  assign panel_vertical_sync_pin_oe_o   = s_q.ctl[ppc_pkg::C_OUT_EN] &
                                          ~s_q.ctl[ppc_pkg::C_VS_TRI];
  assign panel_blank_pin_o              = s_q.blank;
  assign panel_blank_pin_oe_o           = s_q.ctl[ppc_pkg::C_OUT_EN];
  assign panel_data_outputs_o           = s_q.data;
  assign panel_data_outputs_oe_o        = s_q.ctl[ppc_pkg::C_OUT_EN];
  assign panel_clock_outputs_o          = s_q.pclk;
  assign panel_clock_outputs_oe_o       = s_q.ctl[ppc_pkg::C_OUT_EN];
  assign tg_hold_o                      = ~s_q.ctl[ppc_pkg::C_OUT_EN];
  assign legacy_timing_passthrough_mode_o = s_q.ctl[ppc_pkg::C_PASS];

  assign pll_ref_external_o  = s_q.ctl[ppc_pkg::C_CLK_SRC];
  assign clk_pin_pullup_en_o = ~s_q.ctl[ppc_pkg::C_CLK_SRC];
  assign hotplug_int_o       = ~s_q.ctl[ppc_pkg::C_CLK_SRC] &
                               ~external_clock_in_pin_i;
  assign pll_divider_sel_o   = s_q.ctl[ppc_pkg::C_PLL_LOCK] ?
                               ppc_pkg::PLL_SET_PANEL :
                               misc_output_register_clk_sel_i;

  assign ovl_start_o = char_res(s_q.ovr[11:0], s_q.ctl[ppc_pkg::C_OUT_EN]);
  assign ovl_end_o   = 11'(char_res({1'b0, s_q.ovr[26:16]},
                                    s_q.ctl[ppc_pkg::C_OUT_EN]));

  assign gfx_through_palette_o = s_q.pix[ppc_pkg::P_GFX_GAMMA];
  assign ovl_through_palette_o = s_q.pix[ppc_pkg::P_OVL_GAMMA];
  assign crt_ctl_delay_o       = ~s_q.pix[ppc_pkg::P_NO_DELAY];
  assign color_mode_o          = s_q.pix[ppc_pkg::P_MODE_LO +: 4];
  assign color_mode_reserved_o = !(color_mode_o inside {ppc_pkg::MODE_VGA,
                                   ppc_pkg::MODE_8, ppc_pkg::MODE_555,
                                   ppc_pkg::MODE_565, ppc_pkg::MODE_24C,
                                   ppc_pkg::MODE_24U});
  assign fetch_rgb_o           = s_q.fetch;
  assign dac_8bit_o            = s_q.pix[ppc_pkg::P_DAC8];
  assign dac_rdata_o           = s_q.dac_rdata;

endmodule : ppc_top

// ==== tb/ppc_props.sv ====
// Purpose: Port-level checks for the panel output block
// Assumes: Control register shadow follows the register write port
// Notes:   Bound to ppc_top below the module
`timescale 1ns/1ps
module ppc_props (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic [19:0]      reg_addr_i,
  input wire logic [31:0]      reg_wdata_i,
  input wire logic             reg_wr_i,
  input wire logic             reg_rd_i,
  input wire logic [31:0]      reg_rdata_o,
  input wire ppc_pkg::ppc_tg_t tg_i,
  input wire logic             vga_hsync_i,
  input wire logic             vga_vsync_i,
  input wire logic             panel_horizontal_sync_pin_o,
  input wire logic             panel_vertical_sync_pin_o,
  input wire logic             panel_vertical_sync_pin_oe_o,
  input wire logic             panel_data_outputs_oe_o,
  input wire logic             tg_hold_o,
  input wire logic             hotplug_int_o,
  input wire logic [1:0]       misc_output_register_clk_sel_i,
  input wire logic [1:0]       pll_divider_sel_o
);
  // ==========================================================================
  // Control register shadow
  logic [31:0] ctl_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_q <= ppc_pkg::RST_REG;
    end else if (reg_wr_i && reg_addr_i == ppc_pkg::OFS_PANEL_CTL) begin
      ctl_q <= reg_wdata_i & ppc_pkg::MASK_PANEL_CTL;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ==========================================================================
  // Properties
  chk_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data not zero when idle");
  chk_vs_oe: assert property (panel_vertical_sync_pin_oe_o == (ctl_q[31] && !ctl_q[9]))
    else $error("vertical sync enable wrong");
  chk_hold_off: assert property (!ctl_q[31] |-> tg_hold_o && !panel_data_outputs_oe_o)
    else $error("output not off while disabled");
  chk_vs_pass: assert property (ctl_q[31] && ctl_q[28] && ctl_q[11] |=>
    panel_vertical_sync_pin_o == $past(vga_vsync_i)) else $error("vsync not passed through");
  chk_vs_idle: assert property (ctl_q[31] && !ctl_q[28] && ctl_q[11] |=>
    panel_vertical_sync_pin_o == !$past(ctl_q[4])) else $error("vsync not idle level");
  chk_hs_follow: assert property (ctl_q[31] && !ctl_q[28] && !ctl_q[10] |=>
    panel_horizontal_sync_pin_o == ($past(tg_i.hsync) ^ !$past(ctl_q[3])))
    else $error("hsync not from panel timing");
  chk_hotplug_quiet: assert property (ctl_q[1] |-> !hotplug_int_o)
    else $error("hot-plug raised in clock mode");
  chk_lock_sel: assert property (pll_divider_sel_o ==
    (ctl_q[0] ? ppc_pkg::PLL_SET_PANEL : misc_output_register_clk_sel_i))
    else $error("divider set wrong");
endmodule : ppc_props

bind ppc_top ppc_props ppc_props_inst (.*);

// ==== tb/ppc_panel_model.sv ====
// Purpose: Panel receiver and hot-plug pin model
// Assumes: First half of a pixel is on the data lines while clock bit 1 is high
// Notes:   Supplies an external clock on the pin when the pull-up is off
`timescale 1ns/1ps
module ppc_panel_model (
  input  wire logic        clk_i,
  input  wire logic [11:0] data_i,
  input  wire logic        data_oe_i,
  input  wire logic [1:0]  pclk_i,
  input  wire logic        pullup_i,
  input  wire logic        plugged_i,
  output logic             pin_o,
  output logic      [23:0] pix_o,
  output logic             vld_o
);
  logic [11:0] first;
  logic        tog = 1'h0;
  // ==========================================================================
  // Pixel reassembly
  always @(posedge clk_i) begin
    tog <= ~tog;
    if (!data_oe_i) begin
      vld_o <= 1'h0;
    end else if (pclk_i[1]) begin
      first <= data_i;
    end else begin
      pix_o <= {first, data_i};
      vld_o <= 1'h1;
    end
  end
  // Plugged panel pulls low, else pull-up or external clock
  assign pin_o = pullup_i ? !plugged_i : tog;
endmodule : ppc_panel_model

// ==== tb/panel_output_pixel_config_tb.sv ====
// Purpose: Self-checking bench for the panel output block
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Random stimulus from a fixed xorshift seed
`timescale 1ns/1ps
module panel_output_pixel_config_tb;
  logic        clk_i, rst_i, reg_wr_i, reg_rd_i, vga_hsync_i, vga_vsync_i, vga_blank_i;
  logic [19:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, fb_word_i, seed, b;
  logic [23:0] fetch_rgb_o, pix_seen, c;
  logic [11:0] panel_data_outputs_o, ovl_start_o;
  logic [10:0] ovl_end_o;
  logic [7:0]  dac_normal_rdata_i, dac_red_hold_i, dac_green_hold_i, dac_rdata_o;
  logic [5:0]  dac_fsm_status_i;
  logic [3:0]  color_mode_o;
  logic [1:0]  panel_clock_outputs_o, misc_output_register_clk_sel_i, pll_divider_sel_o;
  logic [1:0]  dac_port_sel_i;
  logic        panel_horizontal_sync_pin_o, panel_horizontal_sync_pin_oe_o;
  logic        panel_vertical_sync_pin_o, panel_vertical_sync_pin_oe_o;
  logic        panel_blank_pin_o, panel_blank_pin_oe_o, panel_data_outputs_oe_o;
  logic        panel_clock_outputs_oe_o, tg_hold_o, legacy_timing_passthrough_mode_o;
  logic        external_clock_in_pin_i, clk_pin_pullup_en_o, hotplug_int_o;
  logic        pll_ref_external_o, gfx_through_palette_o, ovl_through_palette_o;
  logic        crt_ctl_delay_o, color_mode_reserved_o, dac_8bit_o, plugged, pix_vld;
  logic [19:0] ofs [5];
  logic [31:0] msk [5];
  int          err_total, n_tests;
  ppc_pkg::ppc_tg_t tg_i;

  ppc_top ppc_top_inst (.*);
  ppc_panel_model ppc_panel_model_inst (.clk_i(clk_i), .data_i(panel_data_outputs_o),
    .data_oe_i(panel_data_outputs_oe_o), .pclk_i(panel_clock_outputs_o),
    .pullup_i(clk_pin_pullup_en_o), .plugged_i(plugged), .pin_o(external_clock_in_pin_i),
    .pix_o(pix_seen), .vld_o(pix_vld));

  initial begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [23:0] exp_pix(input logic [23:0] v, input logic sw, input logic inv);
    logic [23:0] p;
    p = sw ? {v[11:0], v[23:12]} : v;
    return inv ? ~p : p;
  endfunction : exp_pix

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'h1;
    @(posedge clk_i);
    reg_wr_i <= 1'h0;
  endtask : wr

  task automatic rd(input logic [19:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'h1;
    @(posedge clk_i);
    reg_rd_i <= 1'h0;
    #1 chk("reg_rdata_o", reg_rdata_o, exp);
  endtask : rd

  task automatic stir();
    @(posedge clk_i);
    {tg_i, vga_hsync_i, vga_vsync_i, vga_blank_i} <= rnd();
    {dac_normal_rdata_i, dac_red_hold_i, dac_green_hold_i, dac_fsm_status_i,
     dac_port_sel_i} <= rnd();
    {misc_output_register_clk_sel_i, plugged} <= 3'(rnd());
    fb_word_i <= rnd();
  endtask : stir

  // ==========================================================================
  // Main sequence
  initial begin
    seed = 32'h0000_003B;
    err_total = 0;
    n_tests = 0;
    rst_i = 1'h1;
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, fb_word_i, tg_i, plugged} = '0;
    {vga_hsync_i, vga_vsync_i, vga_blank_i, misc_output_register_clk_sel_i} = '0;
    {dac_normal_rdata_i, dac_red_hold_i, dac_green_hold_i, dac_fsm_status_i} = '0;
    dac_port_sel_i = 2'h0;
    ofs = '{ppc_pkg::OFS_PANEL_CTL, ppc_pkg::OFS_OVR_WIN, ppc_pkg::OFS_BORDER,
            ppc_pkg::OFS_PIX_CFG, 20'h60024};
    msk = '{ppc_pkg::MASK_PANEL_CTL, ppc_pkg::MASK_OVR_WIN, ppc_pkg::MASK_BORDER,
            ppc_pkg::MASK_PIX_CFG, 32'h0};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    #1 chk("dac_8bit_o", {31'h0, dac_8bit_o}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      rd(ofs[i], 32'h0);
    end
    for (int i = 0; i < 5; i++) begin
      b = rnd();
      wr(ofs[i], b);
      rd(ofs[i], b & msk[i]);
    end
    for (int i = 0; i < 400; i++) begin
      stir();
      if (i % 10 == 0) begin
        wr(ppc_pkg::OFS_PANEL_CTL, rnd());
      end
    end
    for (int i = 0; i < 4; i++) begin
      c = 24'(rnd());
      wr(ppc_pkg::OFS_PANEL_CTL, 32'h8000_0000 | (32'(i) << 5));
      tg_i <= {5'h0, c};
      repeat (6) @(posedge clk_i);
      #1 chk("pixel", {pix_vld, pix_seen}, {1'h1, exp_pix(c, i[1], i[0])});
    end
    b = rnd();
    wr(ppc_pkg::OFS_BORDER, b);
    for (int i = 0; i < 3; i++) begin
      wr(ppc_pkg::OFS_PANEL_CTL, i == 0 ? 32'h8000_0080 : 32'h8000_0000);
      tg_i <= {3'h0, i != 1, i == 1, 24'h0};
      repeat (6) @(posedge clk_i);
      #1 chk("border", {pix_vld, pix_seen}, {1'h1, i == 2 ? 24'h0 : b[23:0]});
    end
    wr(ppc_pkg::OFS_PANEL_CTL, 32'h0);
    #1 chk("off", {panel_clock_outputs_oe_o, panel_blank_pin_oe_o, tg_hold_o}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      if (i == 2) begin
        wr(ppc_pkg::OFS_PANEL_CTL, 32'h2);
      end
      @(posedge clk_i);
      plugged <= i == 0;
      @(posedge clk_i);
      #1 chk("pin", {pll_ref_external_o, clk_pin_pullup_en_o, hotplug_int_o},
             {i == 2, i < 2, i == 0});
    end
    for (int i = 0; i < 8; i++) begin
      wr(ppc_pkg::OFS_PIX_CFG, (i[0] ? 32'h0C10_8000 : 32'h0) | (32'(i) << 16));
      #1 chk("pix cfg",
             {color_mode_reserved_o, color_mode_o, gfx_through_palette_o,
             ovl_through_palette_o, crt_ctl_delay_o, dac_8bit_o},
             {i == 1 || i == 3, 4'(i), i[0], i[0], !i[0], i[0]});
    end
    @(posedge clk_i);
    fb_word_i <= 32'hA5C3_1E77;
    @(posedge clk_i);
    #1 chk("fetch_rgb_o", {8'h0, fetch_rgb_o}, 32'h00C3_1E77);
    wr(ppc_pkg::OFS_PIX_CFG, 32'h0000_0800);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      {dac_port_sel_i, dac_red_hold_i, dac_green_hold_i, dac_fsm_status_i} <=
        {2'(i), 8'h5A, 8'hC3, 6'h2D};
      @(posedge clk_i);
      #1 chk("dac_rdata_o", i == 2 ? {dac_rdata_o[7:2]} : dac_rdata_o,
             i == 0 ? 8'h5A : i == 1 ? 8'hC3 : 8'h2D);
    end
    b = rnd();
    wr(ppc_pkg::OFS_OVR_WIN, b);
    #1 chk("ovl low", {ovl_end_o, ovl_start_o}, {b[26:19], 3'h0, b[11:3], 3'h0});
    wr(ppc_pkg::OFS_PANEL_CTL, 32'h9000_0104);
    #1 chk("ovl full", {ovl_end_o, ovl_start_o}, {b[26:16], b[11:0]});
    @(posedge clk_i);
    vga_blank_i <= 1'h1;
    misc_output_register_clk_sel_i <= 2'h1;
    @(posedge clk_i);
    #1 chk("pass", {panel_horizontal_sync_pin_oe_o, panel_vertical_sync_pin_oe_o,
           panel_blank_pin_o, legacy_timing_passthrough_mode_o}, 32'h7);
    wr(ppc_pkg::OFS_PANEL_CTL, 32'h8000_0001);
    #1 chk("lock", {30'h0, pll_divider_sel_o}, {30'h0, ppc_pkg::PLL_SET_PANEL});
    test_done();
  end
endmodule : panel_output_pixel_config_tb
